/* File: bench/tb.sv */
// self-checking bench for the uart register front end
// drives the register port and a model of the uart core
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [2:0]  addr = 3'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [3:0]  err = 4'h0;
	logic [3:0]  mdm = 4'h0;
	wire  [31:0] rdata;
	wire  [15:0] div;
	wire  [7:0]  rxb, txb;
	wire         rxv, pop, push, txe, irq;
	wire  [7:0]  lc;
	wire         cmt;
	int          n_fail = 0;
	int          n_checks = 0;
	int          cycles = 0;
	always #10 clk = ~clk;
	urfe_top urfe_top_inst (.i_clk_sys(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_rx_byte(rxb), .i_rx_valid(rxv), .o_rx_pop(pop), .o_tx_byte(txb),
		.o_tx_push(push), .i_tx_empty(txe), .i_overrun(err[0]), .i_parity_err(err[1]),
		.i_framing_err(err[2]), .i_break(err[3]), .i_modem_delta(mdm), .o_divisor(div),
		.o_line_ctrl(lc), .o_commit(cmt), .o_irq(irq));
	urfe_core_model urfe_core_model_inst (.clk, .rx_pop(pop), .tx_push(push), .tx_byte(txb),
		.rx_byte(rxb), .rx_valid(rxv), .tx_empty(txe));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic w(input logic [2:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic r(input logic [2:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			n_fail++;
			complete_run();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		#1 chk(32'(div), 32'h0000_0001);
		r(3'h1, 32'h0000_0000);
		r(3'h5, 32'h0000_0020);
		w(3'h0, 32'hFFFF_FF41);
		@(posedge clk);
		#1 chk(32'(urfe_core_model_inst.last_tx), 32'h0000_0041);
		urfe_core_model_inst.load_rx(8'hA7);
		repeat (2) @(posedge clk);
		r(3'h5, 32'h0000_0021);
		r(3'h0, 32'h0000_00A7);
		r(3'h5, 32'h0000_0020);
		w(3'h1, 32'h0000_000F);
		w(3'h3, 32'h0000_0080);
		r(3'h3, 32'h0000_0080);
		r(3'h1, 32'h0000_0000);
		w(3'h0, 32'h0000_0034);
		w(3'h1, 32'hFFFF_FF12);
		r(3'h1, 32'h0000_0002);
		r(3'h0, 32'h0000_0034);
		chk(urfe_core_model_inst.n_tx, 1);
		chk(32'(div), 32'h0000_0001);
		w(3'h7, 32'h0000_0000);
		#1 chk(32'(cmt), 32'h0000_0001);
		chk(32'(lc), 32'h0000_0080);
		@(posedge clk);
		#1 chk(32'(div), 32'h0000_1234);
		w(3'h1, 32'h0000_000F);
		w(3'h3, 32'h0000_0000);
		#1 chk(32'(irq), 0);
		w(3'h4, 32'h0040_0000);
		#1 chk(32'(irq), 1);
		r(3'h2, 32'h0000_0002);
		@(posedge clk);
		err <= 4'h2;
		@(posedge clk);
		err <= 4'h0;
		r(3'h2, 32'h0000_0006);
		r(3'h5, 32'h0000_0024);
		r(3'h5, 32'h0000_0020);
		mdm <= 4'h5;
		r(3'h6, 32'h0000_0005);
		w(3'h3, 32'h0000_0080);
		w(3'h1, 32'h0000_0001);
		w(3'h3, 32'h0000_0000);
		#1 chk(32'(irq), 0);
		urfe_core_model_inst.load_rx(8'h3C);
		repeat (2) @(posedge clk);
		#1 chk(32'(irq), 1);
		r(3'h2, 32'h0000_0004);
		complete_run();
	end
endmodule
`default_nettype wire

/* File: bench/urfe_checker.sv */
// assertions on the ports of the uart register front end
// assumes select and enables are only changed by register writes
`default_nettype none
module urfe_checker (
	input wire logic        i_clk_sys,
	input wire logic        i_rstn,
	input wire logic [2:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic [7:0]  i_rx_byte,
	input wire logic        i_rx_valid,
	input wire logic        o_rx_pop,
	input wire logic [7:0]  o_tx_byte,
	input wire logic        o_tx_push,
	input wire logic        i_tx_empty,
	input wire logic        o_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       das_q;
	logic       gie_q;
	logic [3:0] ier_q;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			das_q <= 1'b0;
			gie_q <= 1'b0;
			ier_q <= 4'h0;
		end else if (i_wr) begin
			if (i_addr == 3'h3) das_q <= i_wdata[7];
			if (i_addr == 3'h4) gie_q <= i_wdata[22];
			if (i_addr == 3'h1 && das_q) ier_q <= i_wdata[3:0];
		end
	end
	a_upper_zero: assert property (o_rdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_tx_push: assert property (i_wr && i_addr == 3'h0 && !das_q |=>
		o_tx_push && {24'h00_0000, o_tx_byte} == ($past(i_wdata) & 32'h0000_00FF))
		else $error("tx byte not pushed");
	a_div_nopush: assert property (i_wr && das_q |=> !o_tx_push)
		else $error("push with select set");
	a_rx_read: assert property (i_rd && i_addr == 3'h0 && !das_q && i_rx_valid |=>
		o_rx_pop && o_rdata[7:0] == $past(i_rx_byte))
		else $error("rx byte read wrong");
	a_ier_hidden: assert property (i_rd && i_addr == 3'h1 && !das_q |=> o_rdata == 32'h0000_0000)
		else $error("enables visible");
	a_ier_read: assert property (i_rd && i_addr == 3'h1 && das_q |=> o_rdata[7:0] == {4'h0, $past(ier_q)})
		else $error("enables read wrong");
	a_irq_gate: assert property (!gie_q |-> !o_irq)
		else $error("irq without global enable");
	a_rx_irq: assert property (gie_q && ier_q[0] && i_rx_valid |-> o_irq)
		else $error("rx irq missing");
	a_tx_irq: assert property (gie_q && ier_q[1] && i_tx_empty |-> o_irq)
		else $error("tx irq missing");
endmodule
bind urfe_top urfe_checker urfe_checker_inst (.i_clk_sys, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd,
	.o_rdata, .i_rx_byte, .i_rx_valid, .o_rx_pop, .o_tx_byte, .o_tx_push, .i_tx_empty, .o_irq);
`default_nettype wire

/* File: bench/urfe_core_model.sv */
// behavioural uart core at the far side of the front end
// the bench queues receive bytes with load_rx
`default_nettype none
module urfe_core_model (
	input  wire logic       clk,
	input  wire logic       rx_pop,
	input  wire logic       tx_push,
	input  wire logic [7:0] tx_byte,
	output var  logic [7:0] rx_byte,
	output var  logic       rx_valid,
	output var  logic       tx_empty
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rxq [$];
	logic [7:0] last_tx = 8'h00;
	int         n_tx = 0;
	task automatic load_rx(input logic [7:0] b);
		rxq.push_back(b);
	endtask
	always @(posedge clk) begin
		if (rx_pop && rxq.size() != 0) void'(rxq.pop_front());
		if (tx_push) last_tx = tx_byte;
		if (tx_push) n_tx++;
		// holding busy one cycle per byte
		tx_empty <= !tx_push;
		rx_valid <= rxq.size() != 0;
		// no data: line shows a changing pattern
		rx_byte <= rxq.size() != 0 ? rxq[0] : ~rx_byte;
	end
	initial rx_byte = 8'hA5;
endmodule
`default_nettype wire

/* File: hw/urfe_irq_prio.v */
// interrupt priority encoder for the uart register front end
// assumes same-clock level inputs from the uart core
`default_nettype none
`include "urfe_map.vh"

module urfe_irq_prio (
	// enabled source levels
	input  wire       i_line_err,
	input  wire       i_rx_avail,
	input  wire       i_tx_empty,
	input  wire       i_modem_chg,
	// encoded result
	output reg        o_pending,
	output reg  [2:0] o_code
);

	always @* begin
		o_pending = 1'b1;
		o_code    = `URFE_IID_MODEM;
		if (i_line_err) begin
			o_code = `URFE_IID_LINE;
		end else if (i_rx_avail) begin
			o_code = `URFE_IID_RXAV;
		end else if (i_tx_empty) begin
			o_code = `URFE_IID_TXEM;
		end else if (i_modem_chg) begin
			o_code = `URFE_IID_MODEM;
		end else begin
			o_pending = 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: hw/urfe_map.vh */
// register map and field layout of the uart register front end
// assumes word addressing on a plain register port, 32-bit data
`ifndef URFE_MAP_VH
`define URFE_MAP_VH

// register indices (byte address = 4 * index)
`define URFE_IDX_DATA        3'h0
`define URFE_IDX_IER_DLM     3'h1
`define URFE_IDX_IIR         3'h2
`define URFE_IDX_LCR         3'h3
`define URFE_IDX_LSR         3'h5
`define URFE_IDX_MSR         3'h6
`define URFE_IDX_SCR         3'h7
`define URFE_IDX_GIE         3'h4

// field positions
`define URFE_LCR_DAS_BIT     7
`define URFE_IER_RXA_BIT     0
`define URFE_IER_TXE_BIT     1
`define URFE_IER_LSE_BIT     2
`define URFE_IER_MSC_BIT     3
`define URFE_GIE_BIT         22
`define URFE_LSR_DR_BIT      0
`define URFE_LSR_OE_BIT      1
`define URFE_LSR_PE_BIT      2
`define URFE_LSR_FE_BIT      3
`define URFE_LSR_BI_BIT      4
`define URFE_LSR_THRE_BIT    5

// interrupt source codes, bits 3:1 of the id register
`define URFE_IID_LINE        3'h3
`define URFE_IID_RXAV        3'h2
`define URFE_IID_TXEM        3'h1
`define URFE_IID_MODEM       3'h0

// reset values
`define URFE_RST_BYTE        8'h00
`define URFE_RST_IER         4'h0
`define URFE_RST_DIV_LO      8'h01

`endif

/* File: hw/urfe_top.v */
// register front end of an embedded 16550-style uart
// assumes a same-clock register port master and uart core status levels
`default_nettype none
`include "urfe_map.vh"

// Overview of operation
// - rx buffer read at index 0, select clear
// - tx byte written at index 0, select clear
// - enable register reached only with select set
// - global enable bit 22 gates interrupt out
// - enable bit 0 gates rx available
// - enable bit 1 gates tx empty
// - enable bit 2 gates line error
// - enable bit 3 gates modem change
// - reserved bits read as zero
// - divisor low byte at index 0, select set
// - divisor high byte, select set
// - modem control has no function
// - status shows rx full regardless of enable
// - status shows tx empty regardless of enable
// - status shows line error causes
// - upper 24 bits read zero, except global enable bit 22 at index 4
// - id bit 0 low means interrupt pending
// - line status is highest priority code 3
module urfe_top (
	// clock and reset
	input  wire        i_clk_sys,
	input  wire        i_rstn,
	// register port
	input  wire [2:0]  i_addr,
	input  wire [31:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [31:0] o_rdata,
	// uart core receive side
	input  wire [7:0]  i_rx_byte,
	input  wire        i_rx_valid,
	output reg         o_rx_pop,
	// uart core transmit side
	output reg  [7:0]  o_tx_byte,
	output reg         o_tx_push,
	input  wire        i_tx_empty,
	// uart core line and modem status
	input  wire        i_overrun,
	input  wire        i_parity_err,
	input  wire        i_framing_err,
	input  wire        i_break,
	input  wire [3:0]  i_modem_delta,
	// configuration to core
	output reg  [15:0] o_divisor,
	output reg  [7:0]  o_line_ctrl,
	output reg         o_commit,
	// interrupt request
	output wire        o_irq
);

	// raw register state
	reg  [7:0]  line_control_reg_q;
	reg  [3:0]  interrupt_source_enables_q;
	reg  [7:0]  divisor_low_byte_q;
	reg  [7:0]  divisor_high_byte_q;
	reg  [7:0]  scratch_q;
	reg         serial_global_irq_enable_q;
	reg  [4:0]  line_err_q;

	// pending new config until scratch write
	reg  [15:0] divisor_d;
	reg  [7:0]  line_ctrl_d;

	wire        divisor_access_select;
	wire        line_err_now;
	wire        en_rx;
	wire        en_tx;
	wire        en_ls;
	wire        en_ms;
	wire        any_src;
	wire        irq_pending_low;
	wire        pend;
	wire [2:0]  irq_source_code;
	wire [7:0]  line_status_reg;
	wire [7:0]  modem_status_reg;

	function [31:0] urfe_zext;
		input [7:0] b;
		begin
			urfe_zext = {24'h00_0000, b};
		end
	endfunction

	assign divisor_access_select = line_control_reg_q[`URFE_LCR_DAS_BIT];

	// sticky line error causes, cleared when status is read
	assign line_err_now = |line_err_q;

	assign en_rx = interrupt_source_enables_q[`URFE_IER_RXA_BIT] & i_rx_valid;
	assign en_tx = interrupt_source_enables_q[`URFE_IER_TXE_BIT] & i_tx_empty;
	assign en_ls = interrupt_source_enables_q[`URFE_IER_LSE_BIT] & line_err_now;
	assign en_ms = interrupt_source_enables_q[`URFE_IER_MSC_BIT] & (|i_modem_delta);

	urfe_irq_prio u_prio (
		.i_line_err  (en_ls),
		.i_rx_avail  (en_rx),
		.i_tx_empty  (en_tx),
		.i_modem_chg (en_ms),
		.o_pending   (pend),
		.o_code      (irq_source_code)
	);

	assign any_src         = en_rx | en_tx | en_ls | en_ms;
	assign irq_pending_low = ~pend;
	assign o_irq           = any_src & serial_global_irq_enable_q;

	// status bytes, independent of enables
	assign line_status_reg = {2'b00,
		i_tx_empty,
		line_err_q[4:1],
		i_rx_valid};
	assign modem_status_reg = {4'h0, i_modem_delta};

	// register writes
	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			line_control_reg_q         <= `URFE_RST_BYTE;
			interrupt_source_enables_q <= `URFE_RST_IER;
			divisor_low_byte_q         <= `URFE_RST_DIV_LO;
			divisor_high_byte_q        <= `URFE_RST_BYTE;
			scratch_q                  <= `URFE_RST_BYTE;
			serial_global_irq_enable_q <= 1'b0;
			o_tx_byte                  <= `URFE_RST_BYTE;
			o_tx_push                  <= 1'b0;
			o_divisor                  <= {`URFE_RST_BYTE, `URFE_RST_DIV_LO};
			o_line_ctrl                <= `URFE_RST_BYTE;
			o_commit                   <= 1'b0;
		end else begin
			o_tx_push <= 1'b0;
			o_commit  <= 1'b0;
			if (i_wr) begin
				if (i_addr == `URFE_IDX_DATA) begin
					if (divisor_access_select) begin
						divisor_low_byte_q <= i_wdata[7:0];
					end else begin
						o_tx_byte <= i_wdata[7:0];
						o_tx_push <= 1'b1;
					end
				end else if (i_addr == `URFE_IDX_IER_DLM) begin
					if (divisor_access_select) begin
						// enables and high divisor share this slot
						interrupt_source_enables_q <= i_wdata[3:0];
						divisor_high_byte_q        <= i_wdata[7:0];
					end
				end else if (i_addr == `URFE_IDX_LCR) begin
					line_control_reg_q <= i_wdata[7:0];
				end else if (i_addr == `URFE_IDX_GIE) begin
					serial_global_irq_enable_q <= i_wdata[`URFE_GIE_BIT];
				end else if (i_addr == `URFE_IDX_SCR) begin
					// scratch write pushes staged config to core
					scratch_q   <= i_wdata[7:0];
					o_divisor   <= divisor_d;
					o_line_ctrl <= line_ctrl_d;
					o_commit    <= 1'b1;
				end
			end
		end
	end

	always @* begin
		divisor_d   = {divisor_high_byte_q, divisor_low_byte_q};
		line_ctrl_d = line_control_reg_q;
	end

	// sticky line error capture; set wins over read-clear
	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			line_err_q <= 5'h00;
		end else if (i_rd && (i_addr == `URFE_IDX_LSR)) begin
			line_err_q <= {i_break, i_framing_err, i_parity_err, i_overrun, 1'b0};
		end else begin
			line_err_q <= line_err_q | {i_break, i_framing_err, i_parity_err, i_overrun, 1'b0};
		end
	end

	// read path, data one cycle after strobe
	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_rdata  <= 32'h0000_0000;
			o_rx_pop <= 1'b0;
		end else begin
			o_rdata  <= 32'h0000_0000;
			o_rx_pop <= 1'b0;
			if (i_rd) begin
				if (i_addr == `URFE_IDX_DATA) begin
					if (divisor_access_select) begin
						o_rdata <= urfe_zext(divisor_low_byte_q);
					end else begin
						o_rdata  <= urfe_zext(i_rx_byte);
						o_rx_pop <= i_rx_valid;
					end
				end else if (i_addr == `URFE_IDX_IER_DLM) begin
					if (divisor_access_select) begin
						o_rdata <= urfe_zext({4'h0, interrupt_source_enables_q});
					end
				end else if (i_addr == `URFE_IDX_IIR) begin
					o_rdata <= urfe_zext({4'h0, irq_source_code, irq_pending_low});
				end else if (i_addr == `URFE_IDX_LCR) begin
					o_rdata <= urfe_zext(line_control_reg_q);
				end else if (i_addr == `URFE_IDX_GIE) begin
					o_rdata <= {9'h000, serial_global_irq_enable_q, 22'h00_0000};
				end else if (i_addr == `URFE_IDX_LSR) begin
					o_rdata <= urfe_zext(line_status_reg);
				end else if (i_addr == `URFE_IDX_MSR) begin
					o_rdata <= urfe_zext(modem_status_reg);
				end else if (i_addr == `URFE_IDX_SCR) begin
					o_rdata <= urfe_zext(scratch_q);
				end
			end
		end
	end

endmodule
`default_nettype wire
